// ### rtl/rtcm_pkg.sv
package rtcm_pkg;
  // ----------------------------------------
  // bus and register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CAPTURE = 8'h04;
  localparam logic [7:0] OFS_ALARM = 8'h08;
  localparam logic [7:0] OFS_OSC = 8'h0c;
  localparam logic [7:0] OFS_ROUTE = 8'h10;
  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTRL_OSC_EN = 7;
  localparam int CTRL_MISS_EN = 6;
  localparam int CTRL_OSC_FAIL = 5;
  localparam int CTRL_RUN = 4;
  localparam int CTRL_ALARM_EN = 3;
  localparam int CTRL_ALARM_FLAG = 2;
  localparam int CTRL_SET = 1;
  localparam int CTRL_CAPTURE = 0;
  // ----------------------------------------
  // oscillator control fields
  // ----------------------------------------
  localparam int OSC_LFO_SEL = 0;
  localparam int OSC_XTAL_ON = 1;
  localparam int OSC_AUTO_RESET = 2;
  localparam int OSC_XTAL_VALID = 4;
  // ----------------------------------------
  // event routing fields
  // ----------------------------------------
  localparam int RT_ALARM_IRQ = 0;
  localparam int RT_ALARM_WAKE = 1;
  localparam int RT_ALARM_RST = 2;
  localparam int RT_FAIL_IRQ = 3;
  localparam int RT_FAIL_WAKE = 4;
  localparam int RT_FAIL_RST = 5;
  localparam int RT_W = 6;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] RST_TIMER = 32'h0000_0000;
  localparam logic [31:0] RST_ALARM = 32'h0000_0000;
  localparam logic [31:0] RST_CAPTURE = 32'h0000_0000;
  localparam logic [5:0] RST_ROUTE = 6'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MISS_TIME_NS = 100;
  localparam int MISS_TIME_US = 100;
  localparam int MISS_CYCLES_I = (MISS_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] MISS_CYCLES = 12'(MISS_CYCLES_I);
  localparam int BLANK_TIME_MS = 2;
  localparam int BLANK_CYCLES_DEF = (BLANK_TIME_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// ### rtl/rtcm_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - detector enabled: oscillator stuck high or low over 100 us sets fail flag
// R2 - fail timeout may request interrupt, wake or device reset
// R3 - software disables detector before touching oscillator settings
// R4 - crystal-valid reads invalid during 2 ms after crystal turn-on
// R5 - software uses fail flag, not crystal-valid, to detect failure
// R6 - timer counts each oscillator cycle while run is 1, holds otherwise
// R7 - alarm fires only when timer exactly equals match value
// R8 - alarm may request reset, wake or interrupt
// R9 - auto reset clears timer one oscillator cycle after alarm deasserts
// R10 - software programs match two below interval, four with internal oscillator
// R11 - writing 1 at alarm flag position enables auto reset
// R12 - set bit loads capture value into timer, then self-clears
// R13 - capture bit snapshots timer into capture value, then self-clears
// R14 - set and capture work while timer runs
// R15 - software clears alarm enable, writes match, then enables
// R16 - clearing alarm enable clears alarm flag
// R17 - re-enable without new match gives next alarm after full wrap
// R18 - alarm flag lasts at most one oscillator cycle
// R19 - without auto reset the timer wraps to zero and keeps counting
// R20 - internal oscillator selected: timer advances by two per cycle
// R21 - fail flag stays set until software clears it
// R22 - capture takes all 32 bits at one oscillator edge
module rtcm_core
#(
  parameter int BLANK_CYCLES = rtcm_pkg::BLANK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [rtcm_pkg::ADDR_W-1:0] addr,
  input wire logic [rtcm_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [rtcm_pkg::DATA_W-1:0] rdata,
  input wire logic osc_in,
  input wire logic xtal_amp_ok,
  output logic osc_enable,
  output logic lfo_enable,
  output logic xtal_enable,
  output logic irq_req,
  output logic wake_req,
  output logic reset_req
);
  import rtcm_pkg::*;
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [2:0] osc_sync_reg, osc_sync_next;
  logic [2:0] amp_sync_reg, amp_sync_next;
  logic osc_level_reg, osc_level_next;
  logic amp_level_reg, amp_level_next;
  logic [11:0] miss_cnt_reg, miss_cnt_next;
  logic [31:0] blank_cnt_reg, blank_cnt_next;
  logic osc_en_reg, osc_en_next;
  logic miss_en_reg, miss_en_next;
  logic osc_fail_reg, osc_fail_next;
  logic run_reg, run_next;
  logic alarm_en_reg, alarm_en_next;
  logic alarm_flag_reg, alarm_flag_next;
  logic set_pend_reg, set_pend_next;
  logic cap_pend_reg, cap_pend_next;
  logic auto_rst_reg, auto_rst_next;
  logic clr_pend_reg, clr_pend_next;
  logic lfo_sel_reg, lfo_sel_next;
  logic xtal_on_reg, xtal_on_next;
  logic xtal_valid_reg, xtal_valid_next;
  logic [31:0] timer_reg, timer_next;
  logic [31:0] capture_reg, capture_next;
  logic [31:0] alarm_reg, alarm_next;
  logic [RT_W-1:0] route_reg, route_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic wake_reg, wake_next;
  logic rst_reg, rst_next;
  logic osc_stable, osc_change, osc_rise, amp_stable, match, wr_ctrl;
  logic [31:0] step;
  // ----------------------------------------
  // oscillator edge and event detection
  // ----------------------------------------
  // only stages 1 and 2 are compared; stage 0 feeds stage 1 alone
  assign osc_stable = osc_sync_reg[1] == osc_sync_reg[2];
  assign osc_change = osc_stable && (osc_sync_reg[2] != osc_level_reg);
  assign osc_rise = osc_change && osc_sync_reg[2];
  assign amp_stable = amp_sync_reg[1] == amp_sync_reg[2];
  assign match = alarm_en_reg && (timer_reg == alarm_reg); // R7
  assign step = lfo_sel_reg ? 32'h0000_0002 : 32'h0000_0001; // R20
  assign wr_ctrl = wr_stb && (addr == OFS_CTRL);
  always_comb begin
    osc_sync_next = {osc_sync_reg[1:0], osc_in};
    amp_sync_next = {amp_sync_reg[1:0], xtal_amp_ok};
    osc_level_next = osc_stable ? osc_sync_reg[2] : osc_level_reg;
    amp_level_next = amp_stable ? amp_sync_reg[2] : amp_level_reg;
    osc_en_next = osc_en_reg;
    miss_en_next = miss_en_reg;
    osc_fail_next = osc_fail_reg;
    run_next = run_reg;
    alarm_en_next = alarm_en_reg;
    alarm_flag_next = alarm_flag_reg;
    set_pend_next = set_pend_reg;
    cap_pend_next = cap_pend_reg;
    auto_rst_next = auto_rst_reg;
    clr_pend_next = clr_pend_reg;
    lfo_sel_next = lfo_sel_reg;
    xtal_on_next = xtal_on_reg;
    timer_next = timer_reg;
    capture_next = capture_reg;
    alarm_next = alarm_reg;
    route_next = route_reg;
    // count saturates, so the flag is set again every cycle until the stall ends or the detector is disabled
    if (!miss_en_reg || osc_change) begin
      miss_cnt_next = 12'h000;
    end else if (miss_cnt_reg != MISS_CYCLES) begin
      miss_cnt_next = miss_cnt_reg + 12'h001;
    end else begin
      miss_cnt_next = miss_cnt_reg;
    end
    if (!xtal_on_reg) begin
      blank_cnt_next = 32'h0000_0000;
    end else if (blank_cnt_reg != 32'(BLANK_CYCLES)) begin
      blank_cnt_next = blank_cnt_reg + 32'h0000_0001;
    end else begin
      blank_cnt_next = blank_cnt_reg;
    end
    xtal_valid_next = amp_level_reg && (blank_cnt_reg == 32'(BLANK_CYCLES)); // R4
    // ----------------------------------------
    // software writes
    // ----------------------------------------
    if (wr_stb) begin
      case (addr)
        OFS_CTRL: begin
          osc_en_next = wdata[CTRL_OSC_EN];
          miss_en_next = wdata[CTRL_MISS_EN];
          run_next = wdata[CTRL_RUN];
          alarm_en_next = wdata[CTRL_ALARM_EN];
          if (!wdata[CTRL_OSC_FAIL]) begin
            osc_fail_next = 1'b0;
          end
          if (!wdata[CTRL_ALARM_EN]) begin
            alarm_flag_next = 1'b0; // R16
          end
          if (wdata[CTRL_ALARM_FLAG]) begin
            auto_rst_next = 1'b1; // R11
          end
          if (wdata[CTRL_SET]) begin
            set_pend_next = 1'b1;
          end
          if (wdata[CTRL_CAPTURE]) begin
            cap_pend_next = 1'b1;
          end
        end
        OFS_CAPTURE: capture_next = wdata;
        OFS_ALARM: alarm_next = wdata;
        OFS_OSC: begin
          lfo_sel_next = wdata[OSC_LFO_SEL];
          xtal_on_next = wdata[OSC_XTAL_ON];
          auto_rst_next = wdata[OSC_AUTO_RESET];
        end
        OFS_ROUTE: route_next = wdata[RT_W-1:0];
        default: ;
      endcase
    end
    // ----------------------------------------
    // hardware events win over software clears
    // ----------------------------------------
    if (miss_en_reg && miss_cnt_reg == MISS_CYCLES && !osc_change) begin
      osc_fail_next = 1'b1; // R1 R21
    end
    if (osc_rise) begin
      if (set_pend_reg) begin
        timer_next = capture_reg; // R12 R14
        set_pend_next = 1'b0; // R12
      end else if (clr_pend_reg) begin
        timer_next = RST_TIMER; // R9
      end else if (run_reg) begin
        timer_next = timer_reg + step; // R6 R19 R20
      end
      clr_pend_next = 1'b0;
      if (cap_pend_reg) begin
        capture_next = timer_reg; // R13 R22
        cap_pend_next = 1'b0; // R13
      end
      // at most one oscillator cycle, even with a stopped timer sitting on the match
      alarm_flag_next = match && !alarm_flag_reg; // R7 R17 R18
      if (alarm_flag_reg && !match && auto_rst_reg) begin
        clr_pend_next = 1'b1; // R9
      end
    end
    // ----------------------------------------
    // read mux
    // ----------------------------------------
    rdata_next = 32'h0000_0000;
    if (rd_stb) begin
      case (addr)
        OFS_CTRL: begin
          rdata_next[CTRL_OSC_EN] = osc_en_reg;
          rdata_next[CTRL_MISS_EN] = miss_en_reg;
          rdata_next[CTRL_OSC_FAIL] = osc_fail_reg;
          rdata_next[CTRL_RUN] = run_reg;
          rdata_next[CTRL_ALARM_EN] = alarm_en_reg;
          rdata_next[CTRL_ALARM_FLAG] = alarm_flag_reg;
          rdata_next[CTRL_SET] = set_pend_reg;
          rdata_next[CTRL_CAPTURE] = cap_pend_reg;
        end
        OFS_CAPTURE: rdata_next = capture_reg;
        OFS_ALARM: rdata_next = alarm_reg;
        OFS_OSC: begin
          rdata_next[OSC_LFO_SEL] = lfo_sel_reg;
          rdata_next[OSC_XTAL_ON] = xtal_on_reg;
          rdata_next[OSC_AUTO_RESET] = auto_rst_reg;
          rdata_next[OSC_XTAL_VALID] = xtal_valid_reg;
        end
        OFS_ROUTE: rdata_next = {26'h0, route_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    // ----------------------------------------
    // event routing
    // ----------------------------------------
    irq_next = (alarm_flag_reg && route_reg[RT_ALARM_IRQ])
      || (osc_fail_reg && route_reg[RT_FAIL_IRQ]); // R2 R8
    wake_next = (alarm_flag_reg && route_reg[RT_ALARM_WAKE])
      || (osc_fail_reg && route_reg[RT_FAIL_WAKE]); // R2 R8
    rst_next = (alarm_flag_reg && route_reg[RT_ALARM_RST])
      || (osc_fail_reg && route_reg[RT_FAIL_RST]); // R2 R8
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_sync_reg <= 3'h0;
      amp_sync_reg <= 3'h0;
      osc_level_reg <= 1'b0;
      amp_level_reg <= 1'b0;
      miss_cnt_reg <= 12'h000;
      blank_cnt_reg <= 32'h0000_0000;
      osc_en_reg <= 1'b0;
      miss_en_reg <= 1'b0;
      osc_fail_reg <= 1'b0;
      run_reg <= 1'b0;
      alarm_en_reg <= 1'b0;
      alarm_flag_reg <= 1'b0;
      set_pend_reg <= 1'b0;
      cap_pend_reg <= 1'b0;
      auto_rst_reg <= 1'b0;
      clr_pend_reg <= 1'b0;
      lfo_sel_reg <= 1'b0;
      xtal_on_reg <= 1'b0;
      xtal_valid_reg <= 1'b0;
      timer_reg <= RST_TIMER;
      capture_reg <= RST_CAPTURE;
      alarm_reg <= RST_ALARM;
      route_reg <= RST_ROUTE;
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      rst_reg <= 1'b0;
    end else begin
      osc_sync_reg <= osc_sync_next;
      amp_sync_reg <= amp_sync_next;
      osc_level_reg <= osc_level_next;
      amp_level_reg <= amp_level_next;
      miss_cnt_reg <= miss_cnt_next;
      blank_cnt_reg <= blank_cnt_next;
      osc_en_reg <= osc_en_next;
      miss_en_reg <= miss_en_next;
      osc_fail_reg <= osc_fail_next;
      run_reg <= run_next;
      alarm_en_reg <= alarm_en_next;
      alarm_flag_reg <= alarm_flag_next;
      set_pend_reg <= set_pend_next;
      cap_pend_reg <= cap_pend_next;
      auto_rst_reg <= auto_rst_next;
      clr_pend_reg <= clr_pend_next;
      lfo_sel_reg <= lfo_sel_next;
      xtal_on_reg <= xtal_on_next;
      xtal_valid_reg <= xtal_valid_next;
      timer_reg <= timer_next;
      capture_reg <= capture_next;
      alarm_reg <= alarm_next;
      route_reg <= route_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
      rst_reg <= rst_next;
    end
  end

  assign rdata = rdata_reg;
  assign osc_enable = osc_en_reg;
  assign lfo_enable = lfo_sel_reg;
  assign xtal_enable = xtal_on_reg;
  assign irq_req = irq_reg;
  assign wake_req = wake_reg;
  assign reset_req = rst_reg;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_plain_tick;
    osc_rise && !set_pend_reg && !clr_pend_reg;
  endsequence
  sequence s_alarm_end;
    osc_rise && alarm_flag_reg && !match && auto_rst_reg;
  endsequence

  AST_TIMER_RUN: assert property (s_plain_tick and run_reg |=> // R6
    timer_reg == $past(timer_reg) + $past(step)) else $error("timer did not advance");
  AST_TIMER_HOLD: assert property (s_plain_tick and !run_reg |=> // R6
    $stable(timer_reg)) else $error("stopped timer moved");
  AST_STEP_LFO: assert property (s_plain_tick and run_reg && lfo_sel_reg |=> // R20
    timer_reg - $past(timer_reg) == 32'h0000_0002) else $error("lfo step not two");
  AST_ALARM_EQ: assert property (osc_rise |=> // R7
    alarm_flag_reg == $past(match && !alarm_flag_reg)) else $error("alarm flag wrong");
  AST_ALARM_SHORT: assert property (alarm_flag_reg && !osc_rise // R18
    && !(wr_ctrl && !wdata[CTRL_ALARM_EN]) |=> alarm_flag_reg) else $error("alarm flag dropped");
  AST_ALARM_ONCE: assert property (osc_rise && alarm_flag_reg |=> // R18
    !alarm_flag_reg) else $error("alarm flag outlived one cycle");
  AST_AEN_CLR: assert property (wr_ctrl && !wdata[CTRL_ALARM_EN] && !osc_rise |=> // R16
    !alarm_flag_reg) else $error("alarm flag survived disable");
  AST_AUTO_ARM: assert property (s_alarm_end |=> clr_pend_reg ##0 // R9
    !osc_rise [*1]) else $error("auto reset not armed");
  AST_AUTO_CLR: assert property (osc_rise && clr_pend_reg && !set_pend_reg |=> // R9
    timer_reg == 32'h0000_0000) else $error("auto reset did not clear timer");
  AST_SET: assert property (osc_rise && set_pend_reg |=> // R12 R14
    timer_reg == $past(capture_reg) && !set_pend_reg) else $error("set transfer failed");
  AST_CAP: assert property (osc_rise && cap_pend_reg |=> // R13 R22
    capture_reg == $past(timer_reg) && !cap_pend_reg) else $error("capture failed");
  AST_FAIL_SET: assert property (miss_en_reg && miss_cnt_reg == MISS_CYCLES && !osc_change // R1
    |=> osc_fail_reg) else $error("fail flag not set");
  AST_FAIL_STICKY: assert property (osc_fail_reg && !(wr_ctrl && !wdata[CTRL_OSC_FAIL]) // R21
    |=> osc_fail_reg) else $error("fail flag cleared by itself");
  AST_BLANK: assert property (blank_cnt_reg != 32'(BLANK_CYCLES) |=> // R4
    !xtal_valid_reg) else $error("crystal valid inside blanking");
  AST_ROUTE: assert property (alarm_flag_reg && route_reg[RT_ALARM_WAKE] |=> // R8
    wake_req) else $error("alarm wake not raised");
  AST_FAIL_RST: assert property (osc_fail_reg && route_reg[RT_FAIL_RST] |=> // R2
    reset_req) else $error("fail reset not raised");
endmodule // rtcm_core

// ### tb/rtc_timer_alarm_clock_monitor_test.sv
`timescale 1ns/1ps
module rtc_timer_alarm_clock_monitor_test;
  import rtcm_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic osc_in = 1'b0;
  logic xtal_amp_ok = 1'b1;
  logic osc_enable, lfo_enable, xtal_enable, irq_req, wake_req, reset_req;
  logic [31:0] ctrl_base = 32'h0000_0000;
  logic [7:0] offs [6] = '{OFS_CTRL, OFS_CAPTURE, OFS_ALARM, OFS_OSC, OFS_ROUTE, 8'h14};
  int n_fail = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;

  // short blanking keeps the run brief
  rtcm_core #(.BLANK_CYCLES(50)) uut (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .osc_in(osc_in), .xtal_amp_ok(xtal_amp_ok),
    .osc_enable(osc_enable), .lfo_enable(lfo_enable), .xtal_enable(xtal_enable),
    .irq_req(irq_req), .wake_req(wake_req), .reset_req(reset_req)
  );

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_ev(input logic [2:0] exp);
    chk32({29'h0, reset_req, wake_req, irq_req}, {29'h0, exp});
  endtask

  task automatic chk_lvl(input logic [2:0] exp);
    chk32({29'h0, osc_enable, lfo_enable, xtal_enable}, {29'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk32(rdata, exp);
  endtask

  // one full slow cycle, 8 clk high and 8 low
  task automatic osc_ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      osc_in <= 1'b1;
      repeat (8) @(posedge clk);
      osc_in <= 1'b0;
      repeat (7) @(posedge clk);
    end
  endtask

  task automatic set_timer(input logic [31:0] v);
    wr(OFS_CAPTURE, v);
    wr(OFS_CTRL, ctrl_base | 32'h2);
    osc_ticks(1);
    rd_chk(OFS_CTRL, ctrl_base);
  endtask

  task automatic get_timer(input logic [31:0] exp);
    wr(OFS_CTRL, ctrl_base | 32'h1);
    osc_ticks(1);
    rd_chk(OFS_CTRL, ctrl_base);
    rd_chk(OFS_CAPTURE, exp);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // watchdog, well beyond the ~5k cycle run
  // ----------------------------------------
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    chk_lvl(3'b000);
    // wrap, set and capture while running
    ctrl_base = 32'h0000_0090;
    wr(OFS_CTRL, ctrl_base);
    set_timer(32'hffff_fffe);
    chk_lvl(3'b100);
    osc_ticks(1);
    get_timer(32'hffff_ffff);
    get_timer(32'h0000_0000);
    // run cleared: count holds
    ctrl_base = 32'h0000_0080;
    set_timer(32'h1234_5678);
    osc_ticks(3);
    get_timer(32'h1234_5678);
    ctrl_base = 32'h0000_0090;
    wr(OFS_CTRL, ctrl_base);
    osc_ticks(5);
    get_timer(32'h1234_567d);
    // internal oscillator: two per cycle
    wr(OFS_OSC, 32'h1);
    set_timer(32'h0000_0100);
    osc_ticks(3);
    get_timer(32'h0000_0106);
    chk_lvl(3'b110);
    wr(OFS_OSC, 32'h0);
    // alarm through each route
    for (int i = 0; i < 3; i++) begin
      ctrl_base = 32'h0000_0090;
      wr(OFS_CTRL, ctrl_base);
      wr(OFS_ALARM, 32'h0000_0050);
      wr(OFS_ROUTE, 32'h1 << i);
      ctrl_base = 32'h0000_0098;
      wr(OFS_CTRL, ctrl_base);
      set_timer(32'h0000_004e);
      osc_ticks(2);
      rd_chk(OFS_CTRL, 32'h0000_0098);
      chk_ev(3'b000);
      osc_ticks(1);
      rd_chk(OFS_CTRL, 32'h0000_009c);
      chk_ev(3'b001 << i);
      if (i == 0) begin
        wr(OFS_CTRL, 32'h0000_0090);
        rd_chk(OFS_CTRL, 32'h0000_0090);
      end else begin
        osc_ticks(1);
        rd_chk(OFS_CTRL, 32'h0000_0098);
      end
      chk_ev(3'b000);
    end
    // auto reset, match two below the interval
    wr(OFS_CTRL, 32'h0000_009c);
    rd_chk(OFS_OSC, 32'h0000_0004);
    rd_chk(OFS_CTRL, 32'h0000_0098);
    set_timer(32'h0000_004e);
    osc_ticks(4);
    get_timer(32'h0000_0052);
    get_timer(32'h0000_0000);
    wr(OFS_OSC, 32'h0);
    rd_chk(OFS_OSC, 32'h0000_0000);
    wr(OFS_OSC, 32'h4);
    rd_chk(OFS_OSC, 32'h0000_0004);
    wr(OFS_OSC, 32'h0);
    // crystal valid blanking
    wr(OFS_OSC, 32'h2);
    rd_chk(OFS_OSC, 32'h0000_0002);
    repeat (60) @(posedge clk);
    rd_chk(OFS_OSC, 32'h0000_0012);
    chk_lvl(3'b101);
    @(posedge clk);
    xtal_amp_ok <= 1'b0;
    repeat (5) @(posedge clk);
    rd_chk(OFS_OSC, 32'h0000_0002);
    wr(OFS_OSC, 32'h0);
    xtal_amp_ok <= 1'b1;
    wr(OFS_OSC, 32'h2);
    rd_chk(OFS_OSC, 32'h0000_0002);
    wr(OFS_OSC, 32'h0);
    // stalled oscillator, all fail routes
    wr(OFS_ROUTE, 32'h38);
    ctrl_base = 32'h0000_00c0;
    wr(OFS_CTRL, ctrl_base);
    osc_ticks(1);
    repeat (3850) @(posedge clk);
    rd_chk(OFS_CTRL, 32'h0000_00c0);
    chk_ev(3'b000);
    repeat (200) @(posedge clk);
    rd_chk(OFS_CTRL, 32'h0000_00e0);
    chk_ev(3'b111);
    osc_ticks(2);
    rd_chk(OFS_CTRL, 32'h0000_00e0);
    wr(OFS_CTRL, 32'h0000_0080);
    rd_chk(OFS_CTRL, 32'h0000_0080);
    chk_ev(3'b000);
    wrap_up();
  end
endmodule  // rtc_timer_alarm_clock_monitor_test
